// ===== include/clk_cfg_pkg.sv
// register map, field positions, reset values and timing for clock setup
`default_nettype none
package clk_cfg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_RATE = 8'h30;
  localparam logic [7:0] ADDR_RX_DBL_CTRL = 8'h39;
  localparam logic [7:0] ADDR_RX_DBL_OFFSET = 8'h3b;
  localparam logic [7:0] ADDR_RX_DBL_TAP = 8'h3c;
  localparam logic [7:0] ADDR_MULT_ENABLE = 8'h60;
  localparam logic [7:0] ADDR_RX_CLK_DRIVE = 8'h63;
  localparam logic [7:0] ADDR_DUTY_BYPASS = 8'h66;
  localparam logic [7:0] ADDR_TX_SRC_DIV = 8'h71;
  localparam logic [7:0] ADDR_MULT_FACTOR = 8'h72;
  localparam logic [7:0] ADDR_MULT_RESET = 8'h75;
  localparam logic [7:0] ADDR_AUX_CHANNEL = 8'h77;
  localparam logic [7:0] ADDR_AUX_RES_HIGH = 8'h78;
  localparam logic [7:0] ADDR_AUX_RES_LOW = 8'h79;
  localparam logic [7:0] ADDR_AUX_ENABLE = 8'h7a;
  localparam logic [7:0] ADDR_TEMP_ENABLE = 8'h7b;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RATE_RX_DDR_BIT = 0;
  localparam int RATE_TX_DDR_BIT = 1;
  localparam int RX_DBL_SEL_BIT = 1;
  localparam int RX_DBL_RST_BIT = 7;
  localparam int MULT_EN_BIT = 7;
  localparam int DUTY_BYPASS_BIT = 2;
  localparam int TX_DBL_SEL_BIT = 7;
  localparam int TX_FROM_MULT_BIT = 6;
  localparam int MULT_REF_EN_BIT = 4;
  localparam int TX_DIV_MSB = 3;
  localparam int MULT_M_MSB = 5;
  localparam int MULT_LOCK_BIT = 7;
  localparam int MULT_RST_BIT = 3;
  localparam int AUX_START_BIT = 7;
  localparam int AUX_CH_MSB = 2;
  localparam int AUX_EN_BIT = 7;
  localparam int TEMP_EN_BIT = 7;
  localparam int AUX_RES_W = 12;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [AUX_RES_W-1:0] AUX_RES_RESET = 12'h000;
  localparam int AUX_CONV_CYCLES = 16;

endpackage : clk_cfg_pkg
`default_nettype wire

// ===== verilog/level_sync.sv
// two-stage synchroniser for levels arriving from outside the clock domain
`default_nettype none
module level_sync
  import clk_cfg_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  initial
  begin
    if (WIDTH < 1) $error("level_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.stage1 = async_in;
    s_nxt.stage2 = s_r.stage1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sync_out = s_r.stage2;

endmodule : level_sync
`default_nettype wire

// ===== verilog/clk_setup_regs.sv
// clock multiplier, doubler and aux converter configuration registers
`default_nettype none
module clk_setup_regs
  import clk_cfg_pkg::*;
#(
  parameter int CONV_CYCLES = AUX_CONV_CYCLES
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic mult_lock_raw,
  input wire logic [AUX_RES_W-1:0] aux_code_raw,
  output logic mult_enable,
  output logic mult_ref_enable,
  output logic mult_reset,
  output logic [6:0] mult_factor,
  output logic tx_clk_from_mult,
  output logic [TX_DIV_MSB:0] tx_div_n,
  output logic tx_doubler_select,
  output logic rx_doubler_select,
  output logic rx_doubler_reset,
  output logic [7:0] rx_doubler_offset,
  output logic [7:0] rx_doubler_tap,
  output logic [7:0] rx_clk_drive,
  output logic duty_bypass,
  output logic rx_ddr_mode,
  output logic tx_ddr_mode,
  output logic [AUX_CH_MSB:0] aux_channel,
  output logic aux_enable,
  output logic temp_sensor_enable,
  output logic aux_sampling,
  output logic [AUX_RES_W-1:0] aux_converter_result
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] rx_dbl;
    logic [7:0] rx_off;
    logic [7:0] rx_tap;
    logic [7:0] mult_en;
    logic [7:0] rx_drv;
    logic [7:0] bypass;
    logic [7:0] tx_src;
    logic [7:0] mult_m;
    logic [7:0] mult_rst;
    logic [7:0] aux_ch;
    logic [7:0] aux_en;
    logic [7:0] temp_en;
    logic [6:0] factor;
    logic locked;
    logic busy;
    logic [7:0] conv_cnt;
    logic [AUX_RES_W-1:0] aux_res;
    logic [7:0] rdata;
    logic rvalid;
  } cfg_state_t;

  cfg_state_t s_r;
  cfg_state_t s_nxt;
  logic lock_sync;
  logic [AUX_RES_W-1:0] aux_code_sync;
  logic aux_start;

  initial
  begin
    if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
      $error("clk_setup_regs: CONV_CYCLES must lie in 1..255");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  level_sync #(
    .WIDTH(1)
  ) u_lock_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(mult_lock_raw),
    .sync_out(lock_sync)
  );

  // result code is quasi-static while sampling, captured at the end
  level_sync #(
    .WIDTH(AUX_RES_W)
  ) u_aux_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(aux_code_raw),
    .sync_out(aux_code_sync)
  );

  // a start needs both enables already set and no conversion running
  assign aux_start = reg_wr && (reg_addr == ADDR_AUX_CHANNEL)
    && reg_wdata[AUX_START_BIT] && s_r.aux_en[AUX_EN_BIT]
    && s_r.temp_en[TEMP_EN_BIT] && !s_r.busy;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    // register writes; read-only offsets ignore writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_DATA_RATE: s_nxt.rate = reg_wdata;
        ADDR_RX_DBL_CTRL: s_nxt.rx_dbl = reg_wdata;
        ADDR_RX_DBL_OFFSET: s_nxt.rx_off = reg_wdata;
        ADDR_RX_DBL_TAP: s_nxt.rx_tap = reg_wdata;
        ADDR_MULT_ENABLE: s_nxt.mult_en = reg_wdata;
        ADDR_RX_CLK_DRIVE: s_nxt.rx_drv = reg_wdata;
        ADDR_DUTY_BYPASS: s_nxt.bypass = reg_wdata;
        ADDR_TX_SRC_DIV: s_nxt.tx_src = reg_wdata;
        ADDR_MULT_FACTOR: s_nxt.mult_m = reg_wdata;
        ADDR_MULT_RESET: s_nxt.mult_rst = reg_wdata;
        ADDR_AUX_CHANNEL: s_nxt.aux_ch = reg_wdata;
        ADDR_AUX_ENABLE: s_nxt.aux_en = reg_wdata;
        ADDR_TEMP_ENABLE: s_nxt.temp_en = reg_wdata;
        default: ;
      endcase
    end
    // multiply by field plus one
    s_nxt.factor = 7'(s_nxt.mult_m[MULT_M_MSB:0]) + 7'h01;
    // lock only counts while enabled and out of reset
    s_nxt.locked = lock_sync && s_nxt.mult_en[MULT_EN_BIT]
      && !s_nxt.mult_rst[MULT_RST_BIT];
    // aux conversion timer
    if (aux_start)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.conv_cnt = 8'(CONV_CYCLES);
    end
    else if (s_r.busy)
    begin
      if (s_r.conv_cnt == 8'h00)
      begin
        s_nxt.busy = 1'b0;
        s_nxt.aux_res = aux_code_sync;
      end
      else
        s_nxt.conv_cnt = s_r.conv_cnt - 8'h01;
    end
    // register reads answer one cycle later
    if (reg_rd)
    begin
      s_nxt.rvalid = 1'b1;
      case (reg_addr)
        ADDR_DATA_RATE: s_nxt.rdata = s_r.rate;
        ADDR_RX_DBL_CTRL: s_nxt.rdata = s_r.rx_dbl;
        ADDR_RX_DBL_OFFSET: s_nxt.rdata = s_r.rx_off;
        ADDR_RX_DBL_TAP: s_nxt.rdata = s_r.rx_tap;
        ADDR_MULT_ENABLE: s_nxt.rdata = s_r.mult_en;
        ADDR_RX_CLK_DRIVE: s_nxt.rdata = s_r.rx_drv;
        ADDR_DUTY_BYPASS: s_nxt.rdata = s_r.bypass;
        ADDR_TX_SRC_DIV: s_nxt.rdata = s_r.tx_src;
        ADDR_MULT_FACTOR:
          s_nxt.rdata = {s_r.locked, s_r.mult_m[6:0]};
        ADDR_MULT_RESET: s_nxt.rdata = s_r.mult_rst;
        ADDR_AUX_CHANNEL: s_nxt.rdata = s_r.aux_ch;
        ADDR_AUX_RES_HIGH: s_nxt.rdata = s_r.aux_res[11:4];
        ADDR_AUX_RES_LOW: s_nxt.rdata = {s_r.aux_res[3:0], 4'h0};
        ADDR_AUX_ENABLE: s_nxt.rdata = s_r.aux_en;
        ADDR_TEMP_ENABLE: s_nxt.rdata = s_r.temp_en;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // all registers come out of reset at zero except the factor, which loads one; buses single data rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.rate <= REG_RESET;
      s_r.factor <= 7'h01;
      s_r.aux_res <= AUX_RES_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs straight from the state flops
  // ----------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;
  assign mult_enable = s_r.mult_en[MULT_EN_BIT];
  assign mult_ref_enable = s_r.tx_src[MULT_REF_EN_BIT];
  assign mult_reset = s_r.mult_rst[MULT_RST_BIT];
  assign mult_factor = s_r.factor;
  assign tx_clk_from_mult = s_r.tx_src[TX_FROM_MULT_BIT];
  assign tx_div_n = s_r.tx_src[TX_DIV_MSB:0];
  assign tx_doubler_select = s_r.tx_src[TX_DBL_SEL_BIT];
  assign rx_doubler_select = s_r.rx_dbl[RX_DBL_SEL_BIT];
  assign rx_doubler_reset = s_r.rx_dbl[RX_DBL_RST_BIT];
  assign rx_doubler_offset = s_r.rx_off;
  assign rx_doubler_tap = s_r.rx_tap;
  assign rx_clk_drive = s_r.rx_drv;
  assign duty_bypass = s_r.bypass[DUTY_BYPASS_BIT];
  assign rx_ddr_mode = s_r.rate[RATE_RX_DDR_BIT];
  assign tx_ddr_mode = s_r.rate[RATE_TX_DDR_BIT];
  assign aux_channel = s_r.aux_ch[AUX_CH_MSB:0];
  assign aux_enable = s_r.aux_en[AUX_EN_BIT];
  assign temp_sensor_enable = s_r.temp_en[TEMP_EN_BIT];
  assign aux_sampling = s_r.busy;
  assign aux_converter_result = s_r.aux_res;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence aux_go_s;
    aux_start;
  endsequence

  // busy for the programmed count plus one cycle, then idle
  sequence aux_run_s;
    aux_sampling ##CONV_CYCLES aux_sampling ##1 !aux_sampling;
  endsequence

  chk_factor_plus_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_MULT_FACTOR |=>
      mult_factor == 7'($past(reg_wdata[5:0])) + 7'h01)
    else $error("multiplier factor is not field plus one");

  chk_lock_readback: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_MULT_FACTOR |=>
      reg_rvalid && reg_rdata[7] == $past(s_r.locked))
    else $error("lock bit read back wrong");

  chk_lock_qualified: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.locked |-> mult_enable && !mult_reset && $past(lock_sync))
    else $error("lock reported while multiplier off or in reset");

  chk_sdr_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rx_ddr_mode && !tx_ddr_mode
      && !(reg_wr && reg_addr == ADDR_DATA_RATE) |=>
      !rx_ddr_mode && !tx_ddr_mode)
    else $error("data rate left single without a write");

  chk_rx_doubler_sel: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_RX_DBL_CTRL |=>
      rx_doubler_select == $past(reg_wdata[RX_DBL_SEL_BIT])
      && rx_doubler_reset == $past(reg_wdata[RX_DBL_RST_BIT]))
    else $error("receive doubler control not applied");

  chk_tx_doubler_sel: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_TX_SRC_DIV |=>
      tx_doubler_select == $past(reg_wdata[TX_DBL_SEL_BIT]))
    else $error("transmit doubler select not applied");

  chk_aux_split: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_AUX_RES_LOW |=>
      reg_rdata == {$past(aux_converter_result[3:0]), 4'h0})
    else $error("aux low result misplaced");

  chk_aux_high: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_AUX_RES_HIGH |=>
      reg_rdata == $past(aux_converter_result[11:4]))
    else $error("aux high result misplaced");

  chk_aux_conversion: assert property (
    @(posedge clk) disable iff (!rst_n)
    aux_go_s |=> aux_run_s)
    else $error("aux conversion did not run and finish");

endmodule : clk_setup_regs
`default_nettype wire

// ===== tb/analog_side_model.sv
// behavioural multiplier lock source and aux converter code source
`default_nettype none
module analog_side_model
  import clk_cfg_pkg::*;
#(
  parameter int LOCK_CYCLES = 6,
  parameter logic [AUX_RES_W-1:0] AUX_CODE = 12'ha5c
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mult_enable,
  input wire logic mult_reset,
  output logic mult_lock_raw,
  output logic [AUX_RES_W-1:0] aux_code_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  int lock_cnt;
  // lock settles only after enable with reset released for a while
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n || !mult_enable || mult_reset)
    begin
      lock_cnt <= 0;
    end
    else if (lock_cnt < LOCK_CYCLES)
    begin
      lock_cnt <= lock_cnt + 1;
    end
  end
  assign mult_lock_raw = (lock_cnt == LOCK_CYCLES);
  // code held steady so the synchroniser sees one value
  assign aux_code_raw = AUX_CODE;
endmodule : analog_side_model
`default_nettype wire

// ===== tb/test_startup_clock_config_sequence.sv
// register-level tests of the clock setup block
`default_nettype none
module test_startup_clock_config_sequence;
  import clk_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 2;
  localparam logic [11:0] CODE = 12'ha5c;
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, mult_lock_raw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_doubler_offset;
  logic [7:0] rx_doubler_tap, rx_clk_drive;
  logic [11:0] aux_code_raw, aux_converter_result;
  logic mult_enable, mult_ref_enable, mult_reset, tx_clk_from_mult;
  logic [6:0] mult_factor;
  logic [3:0] tx_div_n;
  logic tx_doubler_select, rx_doubler_select, rx_doubler_reset;
  logic duty_bypass, rx_ddr_mode, tx_ddr_mode, aux_enable;
  logic temp_sensor_enable, aux_sampling;
  logic [2:0] aux_channel;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  clk_setup_regs #(.CONV_CYCLES(CONV)) clk_setup_regs_inst (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mult_lock_raw(mult_lock_raw),
    .aux_code_raw(aux_code_raw), .mult_enable(mult_enable),
    .mult_ref_enable(mult_ref_enable), .mult_reset(mult_reset),
    .mult_factor(mult_factor), .tx_clk_from_mult(tx_clk_from_mult),
    .tx_div_n(tx_div_n), .tx_doubler_select(tx_doubler_select),
    .rx_doubler_select(rx_doubler_select),
    .rx_doubler_reset(rx_doubler_reset),
    .rx_doubler_offset(rx_doubler_offset),
    .rx_doubler_tap(rx_doubler_tap), .rx_clk_drive(rx_clk_drive),
    .duty_bypass(duty_bypass), .rx_ddr_mode(rx_ddr_mode),
    .tx_ddr_mode(tx_ddr_mode), .aux_channel(aux_channel),
    .aux_enable(aux_enable), .temp_sensor_enable(temp_sensor_enable),
    .aux_sampling(aux_sampling),
    .aux_converter_result(aux_converter_result));

  analog_side_model #(.AUX_CODE(CODE)) analog_side_model_inst (
    .clk(clk), .rst_n(rst_n), .mult_enable(mult_enable),
    .mult_reset(mult_reset), .mult_lock_raw(mult_lock_raw),
    .aux_code_raw(aux_code_raw));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // bus tasks and compares
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read answer must arrive exactly one cycle after the request
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp("reg_rvalid", 12'h001, {11'h000, reg_rvalid});
    cmp("reg_rdata", {4'h0, exp}, {4'h0, reg_rdata});
  endtask : chk_rd

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp("mult_factor", 12'h001, {5'h00, mult_factor});
    cmp("ddr_modes", 12'h000, {10'h000, rx_ddr_mode, tx_ddr_mode});
    chk_rd(ADDR_MULT_FACTOR, 8'h00);
    $display("test reset values done");
    // multiplier bring-up
    wr(ADDR_MULT_ENABLE, 8'h80);
    wr(ADDR_TX_SRC_DIV, 8'h53);
    cmp("tx_div_n", 12'h003, {8'h00, tx_div_n});
    cmp("mult_src", 12'h007, {9'h000, mult_enable, mult_ref_enable,
        tx_clk_from_mult});
    wr(ADDR_MULT_FACTOR, 8'h3f);
    cmp("mult_factor", 12'h040, {5'h00, mult_factor});
    wr(ADDR_MULT_FACTOR, 8'h09);
    cmp("mult_factor", 12'h00a, {5'h00, mult_factor});
    wr(ADDR_MULT_RESET, 8'h08);
    cmp("mult_reset", 12'h001, {11'h000, mult_reset});
    repeat (12) @(posedge clk);
    chk_rd(ADDR_MULT_FACTOR, 8'h09);
    wr(ADDR_MULT_RESET, 8'h00);
    cmp("mult_reset", 12'h000, {11'h000, mult_reset});
    chk_rd(ADDR_MULT_FACTOR, 8'h09);
    repeat (12) @(posedge clk);
    chk_rd(ADDR_MULT_FACTOR, 8'h89);
    wr(ADDR_MULT_ENABLE, 8'h00);
    chk_rd(ADDR_MULT_FACTOR, 8'h09);
    $display("test multiplier done");
    // receive and transmit doublers
    wr(ADDR_RX_DBL_TAP, 8'h5a);
    cmp("rx_doubler_tap", 12'h05a, {4'h0, rx_doubler_tap});
    wr(ADDR_RX_DBL_TAP, 8'h00);
    cmp("rx_doubler_tap", 12'h000, {4'h0, rx_doubler_tap});
    wr(ADDR_RX_DBL_CTRL, 8'h02);
    cmp("rx_doubler_select", 12'h001, {11'h0, rx_doubler_select});
    wr(ADDR_DUTY_BYPASS, 8'h04);
    cmp("duty_bypass", 12'h001, {11'h000, duty_bypass});
    wr(ADDR_RX_DBL_OFFSET, 8'h55);
    cmp("rx_doubler_offset", 12'h055, {4'h0, rx_doubler_offset});
    wr(ADDR_RX_DBL_CTRL, 8'h82);
    cmp("dbl_rst_sel", 12'h003, {10'h0, rx_doubler_reset,
        rx_doubler_select});
    wr(ADDR_RX_DBL_CTRL, 8'h02);
    cmp("dbl_rst_sel", 12'h001, {10'h0, rx_doubler_reset,
        rx_doubler_select});
    wr(ADDR_RX_CLK_DRIVE, 8'h08);
    cmp("rx_clk_drive", 12'h008, {4'h0, rx_clk_drive});
    wr(ADDR_TX_SRC_DIV, 8'hd3);
    cmp("tx_doubler_select", 12'h001, {11'h0, tx_doubler_select});
    chk_rd(ADDR_RX_DBL_OFFSET, 8'h55);
    wr(ADDR_DATA_RATE, 8'h03);
    cmp("ddr_modes", 12'h003, {10'h000, rx_ddr_mode, tx_ddr_mode});
    $display("test doublers done");
    // temperature conversion, first start refused
    wr(ADDR_AUX_CHANNEL, 8'h83);
    cmp("aux_sampling", 12'h000, {11'h000, aux_sampling});
    wr(ADDR_AUX_CHANNEL, 8'h03);
    cmp("aux_channel", 12'h003, {9'h000, aux_channel});
    wr(ADDR_AUX_ENABLE, 8'h80);
    wr(ADDR_TEMP_ENABLE, 8'h80);
    cmp("aux_enables", 12'h003, {10'h0, aux_enable,
        temp_sensor_enable});
    wr(ADDR_AUX_CHANNEL, 8'h83);
    cmp("aux_sampling", 12'h001, {11'h000, aux_sampling});
    repeat (CONV) @(posedge clk);
    #1;
    cmp("aux_sampling", 12'h001, {11'h000, aux_sampling});
    @(posedge clk);
    #1;
    cmp("aux_sampling", 12'h000, {11'h000, aux_sampling});
    cmp("aux_converter_result", CODE, aux_converter_result);
    chk_rd(ADDR_AUX_RES_HIGH, CODE[11:4]);
    chk_rd(ADDR_AUX_RES_LOW, {CODE[3:0], 4'h0});
    wr(ADDR_AUX_RES_HIGH, 8'hff);
    chk_rd(ADDR_AUX_RES_HIGH, CODE[11:4]);
    chk_rd(8'h10, 8'h00);
    $display("test aux conversion done");
    // mid-run reset returns the buses to single data rate
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp("ddr_modes", 12'h000, {10'h000, rx_ddr_mode, tx_ddr_mode});
    cmp("aux_converter_result", 12'h000, aux_converter_result);
    // regulator disable write leaves the clock setup untouched
    wr(8'h61, 8'hff);
    cmp("mult_factor", 12'h001, {5'h00, mult_factor});
    $display("test mid-run reset done");
    results();
  end
endmodule : test_startup_clock_config_sequence
`default_nettype wire
